//--- srs_pkg.sv
// Function
// - hold internal reset while main supply sits below the power-on threshold.
// - apply a 2.6 ms reset delay before releasing the power-on reset.
// - supervisor enable pin low disables internal power-up and supply-drop reset.
// - supervisor off disables monitor, battery switchover and brownout reset.
// - monitor compares supply against a level chosen by a three-bit select field.
// - monitor works only while its software enable bit is set.
// - read-only monitor output flag shows supply below or above the level.
// - monitor output drives event line 16 on rising, falling or both edges.
// - system reset restores registers except reset-cause flags.
// - system reset from reset pin, both watchdogs, software or low-power reset.
// - each system reset source sets its own readable reset-cause flag.
// - in bypass mode the core-domain pin resets the core logic domain.
// - in bypass mode the core-domain reset pin is not a general-purpose pin.
// - in bypass mode core-domain pin low forbids debug under power-on reset.
// - bypass mode removes standby and over-drive modes.
// - bypass pin high turns the regulator off, core fed from capacitor pins.
package srs_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESET_DELAY_US = 2600;
    // least time, so round up
    localparam int RESET_DELAY_CYCLES = (RESET_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LEVEL_COUNT = 8;

    localparam logic [11:0] ADDR_POWER_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_POWER_STATUS = 12'h004;
    localparam logic [11:0] ADDR_EVENT_CONFIG = 12'h008;
    localparam logic [11:0] ADDR_CLOCK_CTRL_STATUS = 12'h00c;

    // power_control_reg fields
    localparam int PC_MONITOR_ENABLE_BIT = 0;
    localparam int PC_LEVEL_LSB = 1;
    localparam int PC_SOFT_RESET_BIT = 4;
    // power_status_reg fields
    localparam int PS_MONITOR_FLAG_BIT = 0;
    localparam int PS_SUPERVISOR_ON_BIT = 1;
    localparam int PS_BYPASS_BIT = 2;
    // event_config_reg fields
    localparam int EV_RISE_BIT = 0;
    localparam int EV_FALL_BIT = 1;
    localparam int EV_LINE_ENABLE_BIT = 2;
    // clock_ctrl_status_reg fields
    localparam int CS_FLAG_LSB = 0;
    localparam int CS_CLEAR_FLAGS_BIT = 24;
    localparam int EVENT_LINE_NUMBER = 16;

    localparam logic [2:0] LEVEL_RESET = 3'h0;
    localparam logic [5:0] FLAGS_RESET = 6'h02;

    typedef enum logic [1:0] {
        SRS_HOLD,
        SRS_DELAY,
        SRS_RUN
    } srs_state_t;

    typedef struct packed {
        logic low_power;
        logic window_wdg;
        logic indep_wdg;
        logic software;
        logic power_on;
        logic pin;
    } srs_sources_t;

    typedef struct packed {
        logic line_enable;
        logic fall;
        logic rise;
    } srs_event_cfg_t;

    typedef struct packed {
        logic core_from_cap_pins;
        logic regulator_enable;
        logic gpio_core_pin_available;
        logic standby_allowed;
        logic overdrive_allowed;
        logic debug_under_reset_allowed;
        logic brownout_enable;
        logic backup_switch_enable;
    } srs_avail_t;
endpackage

//--- srs_supply_reset_supervisor.sv
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module srs_supply_reset_supervisor #(
    parameter int RESET_DELAY = srs_pkg::RESET_DELAY_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_below_por,
    input wire logic [srs_pkg::LEVEL_COUNT-1:0] supply_below_level,
    input wire logic internal_supervisor_enable,
    input wire logic external_reset_pin_n,
    input wire logic core_domain_reset_pin_n,
    input wire logic regulator_bypass_pin,
    input wire logic window_watchdog_expire,
    input wire logic independent_watchdog_expire,
    input wire logic low_power_reset_req,
    output logic por_reset_n,
    output logic system_reset_n,
    output logic core_domain_reset_n,
    output logic monitor_comparator_enable,
    output logic event_line_pulse,
    output srs_pkg::srs_avail_t availability
);
    import srs_pkg::*;

    localparam int CW = $clog2(RESET_DELAY + 1);
    localparam logic [CW-1:0] DELAY_LAST = CW'(RESET_DELAY - 1);

    generate
        if (RESET_DELAY < 1) begin : g_bad_delay
            $error("reset delay must be at least one cycle");
        end
    endgenerate

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int NSYNC = LEVEL_COUNT + 5;
    localparam logic [NSYNC-1:0] SYNC_IDLE = {{LEVEL_COUNT{1'h0}}, 5'h1c}; // no false cause
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;

    assign async_in = {supply_below_level, supply_below_por, internal_supervisor_enable,
                       external_reset_pin_n, core_domain_reset_pin_n, regulator_bypass_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            // first stage feeds only the second one
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_reg[gi] <= SYNC_IDLE[gi];
                    sync2_reg[gi] <= SYNC_IDLE[gi];
                end else begin
                    sync1_reg[gi] <= async_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    logic bypass_s;
    logic core_pin_n_s;
    logic ext_pin_n_s;
    logic sup_on_s;
    logic below_por_s;
    logic [LEVEL_COUNT-1:0] below_level_s;

    assign bypass_s = sync2_reg[0];
    assign core_pin_n_s = sync2_reg[1];
    assign ext_pin_n_s = sync2_reg[2];
    assign sup_on_s = sync2_reg[3];
    assign below_por_s = sync2_reg[4];
    assign below_level_s = sync2_reg[NSYNC-1:5];

    // ****************************************
    // power-on sequencer
    // ****************************************
    srs_state_t state_reg;
    logic [CW-1:0] delay_cnt_reg;
    logic por_hold;

    // with the supervisor off the external supervisor holds the reset pin instead
    assign por_hold = sup_on_s & below_por_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SRS_HOLD;
        end else begin
            unique case (state_reg)
                SRS_HOLD: begin
                    if (!por_hold) begin
                        state_reg <= sup_on_s ? SRS_DELAY : SRS_RUN;
                    end
                end
                SRS_DELAY: begin
                    if (por_hold) begin
                        state_reg <= SRS_HOLD;
                    end else if (delay_cnt_reg == DELAY_LAST) begin
                        state_reg <= SRS_RUN;
                    end
                end
                SRS_RUN: begin
                    if (por_hold) begin
                        state_reg <= SRS_HOLD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_cnt_reg <= '0;
        end else if (state_reg == SRS_DELAY && !por_hold) begin
            delay_cnt_reg <= delay_cnt_reg + CW'(1);
        end else begin
            delay_cnt_reg <= '0;
        end
    end

    // ****************************************
    // system reset sources
    // ****************************************
    logic soft_reset_reg;
    logic sys_reset_reg;
    srs_sources_t src;

    assign src.pin = ~ext_pin_n_s;
    assign src.power_on = (state_reg != SRS_RUN);
    assign src.software = soft_reset_reg;
    assign src.indep_wdg = independent_watchdog_expire;
    assign src.window_wdg = window_watchdog_expire;
    assign src.low_power = low_power_reset_req;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset_reg <= 1'b1;
        end else begin
            sys_reset_reg <= |src;
        end
    end

    assign por_reset_n = (state_reg == SRS_RUN);
    assign system_reset_n = ~sys_reset_reg;

    // ****************************************
    // registers
    // ****************************************
    logic monitor_enable_reg;
    logic [2:0] level_reg;
    srs_event_cfg_t event_cfg_reg;
    logic [5:0] flags_reg;
    logic wr_en;
    logic rd_setup;
    logic mapped;

    assign mapped = (paddr == ADDR_POWER_CONTROL) || (paddr == ADDR_POWER_STATUS) ||
                    (paddr == ADDR_EVENT_CONFIG) || (paddr == ADDR_CLOCK_CTRL_STATUS);
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // system reset clears control state but leaves the cause flags alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            monitor_enable_reg <= 1'b0;
            level_reg <= LEVEL_RESET;
            soft_reset_reg <= 1'b0;
        end else if (sys_reset_reg) begin
            monitor_enable_reg <= 1'b0;
            level_reg <= LEVEL_RESET;
            soft_reset_reg <= 1'b0;
        end else if (wr_en && paddr == ADDR_POWER_CONTROL) begin
            monitor_enable_reg <= pwdata[PC_MONITOR_ENABLE_BIT];
            level_reg <= pwdata[PC_LEVEL_LSB +: 3];
            soft_reset_reg <= pwdata[PC_SOFT_RESET_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_cfg_reg <= '0;
        end else if (sys_reset_reg) begin
            event_cfg_reg <= '0;
        end else if (wr_en && paddr == ADDR_EVENT_CONFIG) begin
            event_cfg_reg <= pwdata[EV_LINE_ENABLE_BIT:EV_RISE_BIT];
        end
    end

    // a source active in the clearing cycle keeps its flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= FLAGS_RESET;
        end else if (wr_en && paddr == ADDR_CLOCK_CTRL_STATUS && pwdata[CS_CLEAR_FLAGS_BIT]) begin
            flags_reg <= src;
        end else begin
            flags_reg <= flags_reg | src;
        end
    end

    // ****************************************
    // supply voltage monitor
    // ****************************************
    logic monitor_active;
    logic monitor_flag_reg;
    logic monitor_prev_reg;
    logic event_reg;

    // the monitor is dead while the internal supervisor is off
    assign monitor_active = monitor_enable_reg & sup_on_s;
    assign monitor_comparator_enable = monitor_active;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            monitor_flag_reg <= 1'b0;
            monitor_prev_reg <= 1'b0;
        end else begin
            monitor_flag_reg <= monitor_active & below_level_s[level_reg];
            monitor_prev_reg <= monitor_flag_reg;
        end
    end

    // flag high means supply below the level, so its rise is the falling crossing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_reg <= 1'b0;
        end else begin
            event_reg <= event_cfg_reg.line_enable &
                         ((event_cfg_reg.fall & monitor_flag_reg & ~monitor_prev_reg) |
                          (event_cfg_reg.rise & ~monitor_flag_reg & monitor_prev_reg));
        end
    end
    assign event_line_pulse = event_reg;

    // ****************************************
    // read data
    // ****************************************
    logic [31:0] rd_value;
    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (paddr)
            ADDR_POWER_CONTROL: begin
                rd_value[PC_MONITOR_ENABLE_BIT] = monitor_enable_reg;
                rd_value[PC_LEVEL_LSB +: 3] = level_reg;
                rd_value[PC_SOFT_RESET_BIT] = soft_reset_reg;
            end
            ADDR_POWER_STATUS: begin
                rd_value[PS_MONITOR_FLAG_BIT] = monitor_flag_reg;
                rd_value[PS_SUPERVISOR_ON_BIT] = sup_on_s;
                rd_value[PS_BYPASS_BIT] = bypass_s;
            end
            ADDR_EVENT_CONFIG: begin
                rd_value[EV_LINE_ENABLE_BIT:EV_RISE_BIT] = event_cfg_reg;
            end
            ADDR_CLOCK_CTRL_STATUS: begin
                rd_value[CS_FLAG_LSB +: 6] = flags_reg;
            end
            default: begin
                rd_value = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_value;
        end
    end

    // ****************************************
    // core domain and mode availability
    // ****************************************
    logic core_reset_n_reg;
    srs_avail_t avail_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset_n_reg <= 1'b0;
        end else begin
            // bypass has no internal core-supply watch, so the pin is the only guard
            core_reset_n_reg <= bypass_s ? core_pin_n_s : (state_reg == SRS_RUN);
        end
    end
    assign core_domain_reset_n = core_reset_n_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            avail_reg <= '0;
        end else begin
            avail_reg.core_from_cap_pins <= bypass_s;
            avail_reg.regulator_enable <= ~bypass_s;
            avail_reg.gpio_core_pin_available <= ~bypass_s;
            avail_reg.standby_allowed <= ~bypass_s;
            avail_reg.overdrive_allowed <= ~bypass_s;
            avail_reg.debug_under_reset_allowed <= ~(bypass_s & ~core_pin_n_s);
            avail_reg.brownout_enable <= sup_on_s;
            avail_reg.backup_switch_enable <= sup_on_s;
        end
    end
    assign availability = avail_reg;

    // ****************************************
    // checks
    // ****************************************
    chk_hold_por: assert property (@(posedge pclk) disable iff (!presetn)
        por_hold |=> !por_reset_n)
        else $error("power-on reset released while supply low");

    chk_delay_len: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SRS_DELAY) && $past(state_reg) == SRS_DELAY && state_reg == SRS_DELAY
        |-> delay_cnt_reg <= DELAY_LAST)
        else $error("reset delay counter overran");

    chk_delay_exit: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_reg == SRS_RUN) && $past(state_reg) == SRS_DELAY
        |-> $past(delay_cnt_reg) == DELAY_LAST)
        else $error("reset delay ended early");

    chk_sup_off: assert property (@(posedge pclk) disable iff (!presetn)
        !sup_on_s |=> !monitor_flag_reg && !avail_reg.brownout_enable)
        else $error("monitor or brownout alive with supervisor off");

    chk_monitor_off: assert property (@(posedge pclk) disable iff (!presetn)
        !monitor_enable_reg |=> !monitor_flag_reg)
        else $error("monitor flag set while disabled");

    chk_level_pick: assert property (@(posedge pclk) disable iff (!presetn)
        monitor_active |=> monitor_flag_reg == $past(below_level_s[level_reg]))
        else $error("monitor flag does not follow selected level");

    chk_event_fall: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(monitor_flag_reg) && event_cfg_reg.fall && event_cfg_reg.line_enable
        |=> event_line_pulse)
        else $error("missed falling-supply event");

    chk_event_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !event_cfg_reg.line_enable |=> !event_line_pulse)
        else $error("event fired with line disabled");

    chk_src_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (|src) |=> !system_reset_n && ((flags_reg & $past(src)) == $past(src)))
        else $error("reset source without system reset or flag");

    chk_bypass_core: assert property (@(posedge pclk) disable iff (!presetn)
        bypass_s && !core_pin_n_s |=> !core_domain_reset_n && !availability.standby_allowed)
        else $error("core domain not reset by core pin in bypass");

    cov_por_release: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(state_reg == SRS_RUN));
    cov_event: cover property (@(posedge pclk) disable iff (!presetn)
        event_line_pulse);
    cov_soft_reset: cover property (@(posedge pclk) disable iff (!presetn)
        soft_reset_reg ##1 sys_reset_reg);
    cov_bypass: cover property (@(posedge pclk) disable iff (!presetn)
        bypass_s && !core_pin_n_s);
endmodule

//--- srs_ext_partner.sv
`timescale 1ns/1ps
// ****************************************
// external supervisor and reset sources
// ****************************************
module srs_ext_partner (
    input wire logic pclk,
    input wire logic use_external,
    input wire logic power_off,
    input wire logic supply_low,
    input wire logic core_low,
    input wire logic bypass,
    input wire logic pin_req,
    output logic supply_below_por,
    output logic internal_supervisor_enable,
    output logic external_reset_pin_n,
    output logic core_domain_reset_pin_n,
    output logic regulator_bypass_pin
);
    initial begin
        supply_below_por = 1'b1;
        internal_supervisor_enable = 1'b1;
        external_reset_pin_n = 1'b1;
        core_domain_reset_pin_n = 1'b0;
        regulator_bypass_pin = 1'b0;
    end
    always @(posedge pclk) begin
        supply_below_por <= supply_low;
        // pin forced high while powering off, else the part loses safe power down
        internal_supervisor_enable <= !use_external || power_off;
        // push-pull output high while supply low, seen inverted at the reset pin
        external_reset_pin_n <= !(pin_req || (use_external && supply_low));
        // core pin low until both the core and the main supply are good
        core_domain_reset_pin_n <= !(core_low || supply_low);
        regulator_bypass_pin <= bypass;
    end
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
    import srs_pkg::*;
    localparam int RD = 8;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, e;
    logic [LEVEL_COUNT-1:0] lvl = 0;
    logic wwd = 0, iwd = 0, lpr = 0, use_ext = 0, pwr_off = 0;
    logic sup_low = 1, core_low = 1, byp = 0, pin_req = 0;
    logic sbp, ise, erp_n, crp_n, rbp;
    logic por_n, sys_n, core_n, mon_en, ev;
    srs_avail_t avail;
    int n_mismatch = 0, compares = 0, seed = 36699, n_ev = 0, n_rst = 0, cnt, e0, sel, cfg;
    int flag_bit[5] = '{0, 2, 3, 4, 5};

    always #20 pclk = ~pclk;
    always @(posedge pclk) if (ev === 1'b1) n_ev <= n_ev + 1;
    always @(posedge pclk) if (sys_n === 1'b0) n_rst <= n_rst + 1;

    srs_ext_partner partner (.pclk(pclk), .use_external(use_ext), .power_off(pwr_off),
        .supply_low(sup_low), .core_low(core_low), .bypass(byp), .pin_req(pin_req),
        .supply_below_por(sbp), .internal_supervisor_enable(ise),
        .external_reset_pin_n(erp_n), .core_domain_reset_pin_n(crp_n),
        .regulator_bypass_pin(rbp));
    srs_supply_reset_supervisor #(.RESET_DELAY(RD)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_below_por(sbp),
        .supply_below_level(lvl), .internal_supervisor_enable(ise),
        .external_reset_pin_n(erp_n), .core_domain_reset_pin_n(crp_n),
        .regulator_bypass_pin(rbp), .window_watchdog_expire(wwd),
        .independent_watchdog_expire(iwd), .low_power_reset_req(lpr), .por_reset_n(por_n),
        .system_reset_n(sys_n), .core_domain_reset_n(core_n),
        .monitor_comparator_enable(mon_en), .event_line_pulse(ev), .availability(avail));

    // ****************************************
    // helpers
    // ****************************************
    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // entered just after a rising edge; leaves one idle edge so psel never toggles twice
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            results();
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wait_sys();
        int n;
        n = 0;
        while (sys_n !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 200) begin
            n_mismatch++;
            results();
        end
    endtask
    function automatic srs_avail_t exp_avail(input logic b, input logic cl, input logic on);
        return '{b, !b, !b, !b, !b, !(b && cl), on, on};
    endfunction
    function automatic int exp_ev(input int cfg, input int fall);
        return ((cfg >> 2) & (cfg >> fall)) & 1;
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        repeat (20) @(posedge pclk);
        check("por held", por_n, 0);
        check("sys held", sys_n, 0);
        sup_low <= 0;
        cnt = 0;
        while (por_n !== 1'b1 && cnt < 100) begin
            @(posedge pclk);
            cnt++;
        end
        check("por delay", cnt >= RD && cnt <= RD + 8, 1);
        wait_sys();
        apb(0, ADDR_POWER_CONTROL, 0);
        check("pc reset", q, 0);
        apb(0, ADDR_CLOCK_CTRL_STATUS, 0);
        check("power-on flag", q, FLAGS_RESET);
        apb(0, 12'hff0, 0);
        check("unmapped err", e, 1);
        check("unmapped data", q, 0);
        $display("test power-on done");
        for (int k = 0; k < 8; k++) begin
            sel = $random(seed) & 7;
            cfg = k ^ (k >> 1);
            lvl <= 0;
            apb(1, ADDR_EVENT_CONFIG, cfg);
            apb(1, ADDR_POWER_CONTROL, (k & 1) ? 0 : (sel << PC_LEVEL_LSB) | 1);
            check("mon enable", mon_en, (k & 1) ? 0 : 1);
            if ((k & 1) == 0) begin
                lvl <= LEVEL_COUNT'($random(seed));
                repeat (6) @(posedge pclk);
                apb(0, ADDR_POWER_STATUS, 0);
                check("mon flag", q[PS_MONITOR_FLAG_BIT], lvl[sel]);
                lvl <= 0;
                repeat (6) @(posedge pclk);
                e0 = n_ev;
                lvl[sel] <= 1;
                repeat (8) @(posedge pclk);
                check("fall events", n_ev - e0, exp_ev(cfg, 1));
                e0 = n_ev;
                lvl[sel] <= 0;
                repeat (8) @(posedge pclk);
                check("rise events", n_ev - e0, exp_ev(cfg, 0));
            end else begin
                lvl <= 8'hff;
                repeat (6) @(posedge pclk);
                apb(0, ADDR_POWER_STATUS, 0);
                check("mon idle flag", q[PS_MONITOR_FLAG_BIT], 0);
            end
        end
        $display("test monitor done");
        for (int i = 0; i < 5; i++) begin
            apb(1, ADDR_CLOCK_CTRL_STATUS, 32'h1 << CS_CLEAR_FLAGS_BIT);
            apb(0, ADDR_CLOCK_CTRL_STATUS, 0);
            check("flags clear", q, 0);
            apb(1, ADDR_POWER_CONTROL, ($random(seed) & 32'he) | 32'h1);
            apb(1, ADDR_EVENT_CONFIG, 32'h7);
            e0 = n_rst;
            case (i)
                0: pin_req <= 1;
                1: apb(1, ADDR_POWER_CONTROL, 32'h1 << PC_SOFT_RESET_BIT);
                2: iwd <= 1;
                3: wwd <= 1;
                default: lpr <= 1;
            endcase
            repeat (3) @(posedge pclk);
            {pin_req, iwd, wwd, lpr} <= 0;
            repeat (10) @(posedge pclk);
            wait_sys();
            check("reset seen", n_rst > e0, 1);
            apb(0, ADDR_CLOCK_CTRL_STATUS, 0);
            check("cause flag", q, 32'h1 << flag_bit[i]);
            apb(0, ADDR_POWER_CONTROL, 0);
            check("pc restored", q, 0);
            apb(0, ADDR_EVENT_CONFIG, 0);
            check("ev restored", q, 0);
        end
        $display("test reset sources done");
        check("avail reg on", avail, exp_avail(0, 0, 1));
        presetn <= 0;
        use_ext <= 1;
        sup_low <= 1;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        repeat (10) @(posedge pclk);
        check("por off", por_n, 1);
        check("ext held", sys_n, 0);
        sup_low <= 0;
        repeat (4) @(posedge pclk);
        wait_sys();
        apb(1, ADDR_POWER_CONTROL, 1);
        check("mon off", mon_en, 0);
        apb(0, ADDR_POWER_STATUS, 0);
        check("sup on bit", q[PS_SUPERVISOR_ON_BIT], 0);
        for (int b = 0; b < 4; b++) begin
            byp <= b[1];
            core_low <= b[0];
            repeat (6) @(posedge pclk);
            check("avail", avail, exp_avail(b[1], b[0], 0));
            check("core reset", core_n, (b >= 2) ? !b[0] : 1);
            apb(0, ADDR_POWER_STATUS, 0);
            check("bypass bit", q[PS_BYPASS_BIT], b[1]);
        end
        pwr_off <= 1;
        repeat (4) @(posedge pclk);
        $display("test supervisor off done");
        results();
    end
endmodule
